// *** hw/lpss_seq.sv ***
// Top of the low power state sequencer.
// Contract
// [R1] Three low-power modes, active, sleep and deep sleep, exist beside the unpowered Off state.
// [R2] While chip enable is low the sequencer is Off, the always-on domain is disabled and all state is cleared.
// [R3] In deep sleep only the always-on domain is powered.
// [R4] The always-on timer keeps counting in deep sleep.
// [R5] The retention memory keeps its contents through deep sleep; a deep sleep timer wake pulses the external reset, which clears it.
// [R6] In Sleep only the always-on domain runs and the crystal enable is low.
// [R7] A wake event from MAC, host, timer or external line moves a sleep state to Wakeup.
// [R8] Wakeup enables the crystal and PLLs and then moves to the powered state.
// [R9] In On the fast clock runs and reaches only blocks whose enable bit is set.
// [R10] The processor clock is gated off while it waits for an interrupt in On.
// [R11] When the chip powers down, pad output enables may be held low.
// [R12] The board ties the deep sleep wake pin to the external reset input.
// [R13] The external reset input is active low and resets the chip.
// [R14] On is entered only after crystal and PLLs are stable, and a low chip enable forces Off from any state.
`timescale 1ns/10ps
module lpss_seq (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        chip_power_enable_pin,
   input  wire logic        external_reset_n,
   input  wire logic [1:0]  sleep_mode_req,
   input  wire logic        sleep_req,
   input  wire logic [3:0]  wake_event,
   input  wire logic [31:0] rtc_alarm,
   input  wire logic        xtal_stable,
   input  wire logic        pll_stable,
   input  wire logic [7:0]  clk_ctrl,
   input  wire logic        clk_ctrl_wr,
   input  wire logic        wait_for_irq_instruction,
   input  wire logic        cpu_irq,
   input  wire logic        pad_hold_cfg,
   input  wire logic        ret_wr_en,
   input  wire logic [1:0]  ret_addr,
   input  wire logic [31:0] ret_wdata,
   output logic [31:0]      ret_rdata,
   output logic [2:0]       power_state,
   output logic             rtc_domain_en,
   output logic             rtc_clk_en,
   output logic             main_power_en,
   output logic             xtal_en,
   output logic             pll_en,
   output logic [7:0]       block_clk_en,
   output logic             cpu_clk_en,
   output logic             pad_oe_hold_low,
   output logic             deep_sleep_wake_pin_o,
   output logic             deep_sleep_wake_pin_oe,
   output logic [31:0]      rtc_count
);

   // ****************************************
   // Reset and wake decode
   // ****************************************
   lpss_pkg::lpss_state_e state_q;
   lpss_pkg::lpss_state_e state_d;
   logic [7:0]  clk_en_q;
   logic [31:0] rtc_q;
   logic        hold_cfg_q;
   logic        wfi_q;
   logic [3:0]  pulse_q;
   logic        rtc_ram_hit_q;

   // Both the pin and the internal reset clear state, clock mask and retention memory; the pin leaves the timer and wake pulse running.
   wire chip_reset   = rst | ~external_reset_n;          // see [R13]
   wire chip_off     = ~chip_power_enable_pin;          // see [R2]
   wire any_wake     = |wake_event | rtc_ram_hit_q;     // see [R7]
   wire clocks_ready = xtal_stable & pll_stable;
   wire rtc_hit      = (rtc_q == rtc_alarm);
   wire in_sleep     = (state_q == lpss_pkg::LPSS_SLEEP) | (state_q == lpss_pkg::LPSS_DEEP_SLEEP);

   // ****************************************
   // State machine
   // ****************************************
   always_comb begin
      state_d = state_q;
      case (state_q)
         lpss_pkg::LPSS_OFF: begin
            state_d = lpss_pkg::LPSS_WAKEUP;
         end
         lpss_pkg::LPSS_WAKEUP: begin
            if (clocks_ready) begin
               state_d = lpss_pkg::LPSS_ON;              // see [R14]
            end
         end
         lpss_pkg::LPSS_ON: begin
            if (sleep_req && sleep_mode_req == lpss_pkg::LPSS_MODE_SLEEP) begin
               state_d = lpss_pkg::LPSS_SLEEP;           // see [R1]
            end else if (sleep_req && sleep_mode_req == lpss_pkg::LPSS_MODE_DEEP) begin
               state_d = lpss_pkg::LPSS_DEEP_SLEEP;      // see [R1]
            end
         end
         lpss_pkg::LPSS_SLEEP, lpss_pkg::LPSS_DEEP_SLEEP: begin
            if (any_wake) begin
               state_d = lpss_pkg::LPSS_WAKEUP;          // see [R7]
            end
         end
         default: begin
            state_d = lpss_pkg::LPSS_OFF;
         end
      endcase
      if (chip_off) begin
         state_d = lpss_pkg::LPSS_OFF;                   // see [R14]
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= lpss_pkg::LPSS_OFF;
      end else if (~external_reset_n) begin
         state_q <= lpss_pkg::LPSS_OFF;                  // see [R13]
      end else begin
         state_q <= state_d;
      end
   end

   // ****************************************
   // Clock control, pad hold and processor gating
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         clk_en_q   <= lpss_pkg::LPSS_CLK_EN_RST;
         hold_cfg_q <= 1'b0;
         wfi_q      <= 1'b0;
      end else if (chip_reset || chip_off) begin
         clk_en_q   <= lpss_pkg::LPSS_CLK_EN_RST;       // see [R2]
         hold_cfg_q <= 1'b0;
         wfi_q      <= 1'b0;
      end else begin
         if (clk_ctrl_wr) begin
            clk_en_q <= clk_ctrl;
         end
         hold_cfg_q <= pad_hold_cfg;
         // An interrupt wins over a new wait so the processor never stalls on a pending request.
         if (state_q != lpss_pkg::LPSS_ON || cpu_irq) begin
            wfi_q <= 1'b0;
         end else if (wait_for_irq_instruction) begin
            wfi_q <= 1'b1;                               // see [R10]
         end
      end
   end

   // ****************************************
   // Always-on timer and wake pin pulse
   // ****************************************
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rtc_q         <= lpss_pkg::LPSS_RTC_RST;
         pulse_q       <= 4'h0;
         rtc_ram_hit_q <= 1'b0;
      end else if (chip_off) begin
         rtc_q         <= lpss_pkg::LPSS_RTC_RST;       // see [R2]
         pulse_q       <= 4'h0;
         rtc_ram_hit_q <= 1'b0;
      end else begin
         // Counts in every powered state, deep sleep included.
         rtc_q         <= rtc_q + 32'h0000_0001;         // see [R4]
         rtc_ram_hit_q <= rtc_hit & in_sleep;
         if (state_q == lpss_pkg::LPSS_DEEP_SLEEP && rtc_hit) begin
            pulse_q <= lpss_pkg::LPSS_WAKE_PULSE_CNT;
         end else if (pulse_q != 4'h0) begin
            pulse_q <= pulse_q - 4'h1;
         end
      end
   end

   // ****************************************
   // Retention memory
   // ****************************************
   lpss_ret_if ret_bus ();

   assign ret_bus.wr_en = ret_wr_en & (state_q == lpss_pkg::LPSS_ON);
   assign ret_bus.addr  = ret_addr;
   assign ret_bus.wdata = ret_wdata;
   assign ret_bus.clear = chip_off | ~external_reset_n;  // see [R2]

   lpss_ret_mem lpss_ret_mem_i (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ret     (ret_bus.mem)
   );

   // ****************************************
   // Outputs
   // ****************************************
   wire st_on     = (state_q == lpss_pkg::LPSS_ON);
   wire st_wakeup = (state_q == lpss_pkg::LPSS_WAKEUP);
   wire st_off    = (state_q == lpss_pkg::LPSS_OFF);
   wire st_down   = st_off | (state_q == lpss_pkg::LPSS_DEEP_SLEEP);

   assign ret_rdata              = ret_bus.rdata;
   assign power_state            = state_q;
   assign rtc_domain_en          = ~st_off;                     // see [R2]
   assign rtc_clk_en             = ~st_off;                     // see [R4]
   assign main_power_en          = ~st_down;                    // see [R3]
   assign xtal_en                = st_on | st_wakeup;           // see [R6] [R8]
   assign pll_en                 = st_on | st_wakeup;           // see [R8]
   assign block_clk_en           = st_on ? clk_en_q : 8'h00;    // see [R9]
   assign cpu_clk_en             = st_on & ~wfi_q;              // see [R10]
   assign pad_oe_hold_low        = hold_cfg_q & ~main_power_en; // see [R11]
   assign deep_sleep_wake_pin_o  = 1'b0;                        // see [R12]
   assign deep_sleep_wake_pin_oe = (pulse_q != 4'h0);
   assign rtc_count              = rtc_q;

   // ****************************************
   // Checks
   // ****************************************
   chk_off_forced: assert property (@(posedge ref_clk) disable iff (rst) // see [R14]
      chip_off |=> (state_q == lpss_pkg::LPSS_OFF))
      else $error("Low chip enable did not force Off.");
   chk_off_clear: assert property (@(posedge ref_clk) disable iff (rst) // see [R2]
      chip_off |=> (rtc_q == 32'h0) && !rtc_domain_en)
      else $error("Off state did not clear the always-on domain.");
   chk_deep_power: assert property (@(posedge ref_clk) disable iff (rst) // see [R3]
      (state_q == lpss_pkg::LPSS_DEEP_SLEEP) |-> !main_power_en && rtc_domain_en)
      else $error("Deep sleep powers more than the always-on domain.");
   chk_rtc_counts: assert property (@(posedge ref_clk) disable iff (rst) // see [R4]
      ((state_q == lpss_pkg::LPSS_DEEP_SLEEP) && !chip_off) |=> (rtc_q == $past(rtc_q) + 32'h1))
      else $error("Timer stopped in deep sleep.");
   chk_sleep_xtal: assert property (@(posedge ref_clk) disable iff (rst) // see [R6]
      in_sleep |-> !xtal_en && !pll_en && block_clk_en == 8'h00)
      else $error("Crystal enabled in a sleep state.");
   chk_wake_move: assert property (@(posedge ref_clk) disable iff (rst) // see [R7]
      (in_sleep && |wake_event && !chip_off && external_reset_n) |=> st_wakeup)
      else $error("Wake event did not reach Wakeup.");
   chk_on_ready: assert property (@(posedge ref_clk) disable iff (rst) // see [R14]
      (st_wakeup && !clocks_ready) |=> !st_on)
      else $error("On entered before clocks were stable.");
   chk_wakeup_clk: assert property (@(posedge ref_clk) disable iff (rst) // see [R8]
      st_wakeup |-> xtal_en && pll_en)
      else $error("Wakeup did not enable crystal and PLLs.");
   chk_block_gate: assert property (@(posedge ref_clk) disable iff (rst) // see [R9]
      (st_on && clk_ctrl_wr && !chip_off && external_reset_n && state_d == lpss_pkg::LPSS_ON)
      |=> block_clk_en == $past(clk_ctrl))
      else $error("Block clocks do not follow clock control.");
   chk_cpu_gate: assert property (@(posedge ref_clk) disable iff (rst) // see [R10]
      (st_on && wait_for_irq_instruction && !cpu_irq && !chip_off && external_reset_n && state_d == lpss_pkg::LPSS_ON)
      |=> !cpu_clk_en)
      else $error("Processor clock not gated on wait.");
   chk_ext_reset: assert property (@(posedge ref_clk) disable iff (rst) // see [R13]
      !external_reset_n |=> st_off)
      else $error("External reset did not reset the sequencer.");
   chk_pad_hold: assert property (@(posedge ref_clk) disable iff (rst) // see [R11]
      (pad_hold_cfg && !chip_reset && !chip_off) |=> (pad_oe_hold_low == st_down))
      else $error("Pad enables not held low at power down.");

endmodule : lpss_seq

// *** common/lpss_pkg.sv ***
// Package of states, widths and timing constants for the low power state sequencer.
package lpss_pkg;

   // ****************************************
   // Power states
   // ****************************************
   typedef enum logic [2:0] {
      LPSS_OFF,
      LPSS_DEEP_SLEEP,
      LPSS_SLEEP,
      LPSS_WAKEUP,
      LPSS_ON
   } lpss_state_e;

   // Requested low-power mode when software asks to sleep.
   typedef enum logic [1:0] {
      LPSS_MODE_ACTIVE,
      LPSS_MODE_SLEEP,
      LPSS_MODE_DEEP
   } lpss_mode_e;

   // ****************************************
   // Widths and reset values
   // ****************************************
   localparam int unsigned LPSS_NUM_BLOCKS   = 8;
   localparam int unsigned LPSS_NUM_WAKE     = 4;
   localparam int unsigned LPSS_RET_WORDS    = 4;
   localparam int unsigned LPSS_RET_WIDTH    = 32;
   localparam int unsigned LPSS_RET_AW       = 2;
   localparam int unsigned LPSS_RTC_WIDTH    = 32;

   localparam logic [7:0]  LPSS_CLK_EN_RST   = 8'h00;
   localparam logic [31:0] LPSS_RET_RST      = 32'h0000_0000;
   localparam logic [31:0] LPSS_RTC_RST      = 32'h0000_0000;

   // Wake source bit positions.
   localparam int unsigned LPSS_WAKE_MAC     = 0;
   localparam int unsigned LPSS_WAKE_HOST    = 1;
   localparam int unsigned LPSS_WAKE_RTC     = 2;
   localparam int unsigned LPSS_WAKE_EXT     = 3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned LPSS_CLK_PERIOD_NS = 100;
   // Pulse width on the deep sleep wake pin, long enough to reset the chip.
   localparam int unsigned LPSS_WAKE_PULSE_NS = 1000;
   localparam int unsigned LPSS_WAKE_PULSE_CYC =
      (LPSS_WAKE_PULSE_NS + LPSS_CLK_PERIOD_NS - 1) / LPSS_CLK_PERIOD_NS;
   localparam logic [3:0]  LPSS_WAKE_PULSE_CNT = 4'(LPSS_WAKE_PULSE_CYC);

endpackage : lpss_pkg

// *** common/lpss_ret_if.sv ***
// Interface carrying accesses to the retention memory.
`timescale 1ns/10ps
interface lpss_ret_if;
   logic        wr_en;
   logic [1:0]  addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   logic        clear;

   modport seq (output wr_en, output addr, output wdata, output clear, input rdata);
   modport mem (input wr_en, input addr, input wdata, input clear, output rdata);
endinterface : lpss_ret_if

// *** hw/lpss_ret_mem.sv ***
// Retention memory of the always-on domain.
`timescale 1ns/10ps
module lpss_ret_mem (
   input  wire logic ref_clk,
   input  wire logic rst,
   lpss_ret_if.mem   ret
);
   logic [31:0] mem_q [lpss_pkg::LPSS_RET_WORDS];
   logic [31:0] rdata_q;

   // Contents are only lost on reset or a low chip enable, never on sleep.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < lpss_pkg::LPSS_RET_WORDS; i++) begin
            mem_q[i] <= lpss_pkg::LPSS_RET_RST;
         end
         rdata_q <= lpss_pkg::LPSS_RET_RST;
      end else if (ret.clear) begin
         for (int i = 0; i < lpss_pkg::LPSS_RET_WORDS; i++) begin
            mem_q[i] <= lpss_pkg::LPSS_RET_RST;
         end
         rdata_q <= lpss_pkg::LPSS_RET_RST;
      end else begin
         if (ret.wr_en) begin
            mem_q[ret.addr] <= ret.wdata; // see [R5]
         end
         rdata_q <= mem_q[ret.addr];
      end
   end

   assign ret.rdata = rdata_q;
endmodule : lpss_ret_mem

// *** test/lpss_partner.sv ***
// Partner model: oscillator and loop settling, and the board tie of the wake pin to reset.
`timescale 1ns/10ps
module lpss_partner (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic slow,
   input  wire logic xtal_en,
   input  wire logic pll_en,
   input  wire logic wake_pin_o,
   input  wire logic wake_pin_oe,
   input  wire logic board_reset_n,
   output logic      xtal_stable,
   output logic      pll_stable,
   output logic      external_reset_n
);
   logic [3:0] settle_q;

   // Stable is reported only after a settling count, so the sequencer cannot rely on it at once.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         settle_q <= 4'h0;
      end else if (!xtal_en || !pll_en) begin
         settle_q <= 4'h0;
      end else if (settle_q != 4'hf) begin
         settle_q <= settle_q + 4'h1;
      end
   end

   assign xtal_stable = xtal_en && (settle_q >= (slow ? 4'h6 : 4'h1));
   assign pll_stable  = pll_en && (settle_q >= (slow ? 4'h8 : 4'h2));
   // The wake pin is pulled up on the board and wired to the reset input.
   assign external_reset_n = board_reset_n && (wake_pin_oe ? wake_pin_o : 1'b1);
endmodule : lpss_partner

// *** test/lpss_seq_tb.sv ***
// Self-checking testbench of the low power state sequencer.
`timescale 1ns/10ps
module lpss_seq_tb;
   logic ref_clk, rst, chip_en, board_reset_n, slow, sleep_req, clk_ctrl_wr, wfi, cpu_irq, pad_hold_cfg;
   logic xtal_stable, pll_stable, external_reset_n, ret_wr_en;
   logic [1:0] sleep_mode_req, ret_addr;
   logic [3:0] wake_event;
   logic [7:0] clk_ctrl, block_clk_en;
   logic [31:0] rtc_alarm, ret_wdata, ret_rdata, rtc_count, cnt;
   logic [2:0] power_state;
   logic rtc_domain_en, rtc_clk_en, main_power_en, xtal_en, pll_en, cpu_clk_en, pad_oe_hold_low, wake_o, wake_oe;
   int bad_count, n_compared, cycles;

   lpss_seq lpss_seq_i (.ref_clk(ref_clk), .rst(rst), .chip_power_enable_pin(chip_en),
      .external_reset_n(external_reset_n), .sleep_mode_req(sleep_mode_req), .sleep_req(sleep_req),
      .wake_event(wake_event), .rtc_alarm(rtc_alarm), .xtal_stable(xtal_stable), .pll_stable(pll_stable),
      .clk_ctrl(clk_ctrl), .clk_ctrl_wr(clk_ctrl_wr), .wait_for_irq_instruction(wfi), .cpu_irq(cpu_irq),
      .pad_hold_cfg(pad_hold_cfg), .ret_wr_en(ret_wr_en), .ret_addr(ret_addr), .ret_wdata(ret_wdata),
      .ret_rdata(ret_rdata), .power_state(power_state), .rtc_domain_en(rtc_domain_en), .rtc_clk_en(rtc_clk_en),
      .main_power_en(main_power_en), .xtal_en(xtal_en), .pll_en(pll_en), .block_clk_en(block_clk_en),
      .cpu_clk_en(cpu_clk_en), .pad_oe_hold_low(pad_oe_hold_low), .deep_sleep_wake_pin_o(wake_o),
      .deep_sleep_wake_pin_oe(wake_oe), .rtc_count(rtc_count));
   lpss_partner lpss_partner_i (.ref_clk(ref_clk), .rst(rst), .slow(slow), .xtal_en(xtal_en), .pll_en(pll_en),
      .wake_pin_o(wake_o), .wake_pin_oe(wake_oe), .board_reset_n(board_reset_n), .xtal_stable(xtal_stable),
      .pll_stable(pll_stable), .external_reset_n(external_reset_n));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Checking helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : step

   // Bounded wait, so a stuck sequencer is reported rather than hanging.
   task automatic wait_state(input lpss_pkg::lpss_state_e s, input int lim);
      for (int i = 0; i < lim && power_state !== s; i++) step(1);
      chk(power_state, s, "state not reached");
   endtask : wait_state

   task automatic go_sleep(input lpss_pkg::lpss_mode_e m);
      sleep_mode_req = m;
      sleep_req = 1'b1;
      step(1);
      sleep_req = 1'b0;
   endtask : go_sleep

   task automatic finish_test;
      $display("bad_count %0d n_compared %0d", bad_count, n_compared);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_power_up;
      chk(power_state, lpss_pkg::LPSS_OFF, "off in reset");
      chk({rtc_domain_en, xtal_en, main_power_en}, 0, "enables in reset");
      rst = 1'b0;
      step(1);
      chk(power_state, lpss_pkg::LPSS_WAKEUP, "wakeup after enable");
      chk({xtal_en, pll_en}, 3, "xtal pll in wakeup");
      step(3);
      chk(power_state, lpss_pkg::LPSS_WAKEUP, "on before stable");
      wait_state(lpss_pkg::LPSS_ON, 20);
      chk(block_clk_en, 0, "mask after reset");
      $display("power up done");
   endtask : t_power_up

   task automatic t_gating;
      clk_ctrl = 8'h5a;
      clk_ctrl_wr = 1'b1;
      step(1);
      clk_ctrl_wr = 1'b0;
      clk_ctrl = 8'h00;
      step(1);
      chk(block_clk_en, 8'h5a, "block mask");
      wfi = 1'b1;
      step(1);
      wfi = 1'b0;
      step(1);
      chk(cpu_clk_en, 0, "cpu gated");
      cpu_irq = 1'b1;
      step(1);
      cpu_irq = 1'b0;
      step(1);
      chk(cpu_clk_en, 1, "cpu ungated");
      go_sleep(lpss_pkg::LPSS_MODE_ACTIVE);
      chk(power_state, lpss_pkg::LPSS_ON, "active mode stays on");
      step(1);
      $display("gating done");
   endtask : t_gating

   task automatic t_sleep_wake;
      slow = 1'b0;
      for (int i = 0; i < 4; i++) begin
         go_sleep(lpss_pkg::LPSS_MODE_SLEEP);
         chk(power_state, lpss_pkg::LPSS_SLEEP, "sleep entry");
         chk({xtal_en, rtc_clk_en, block_clk_en}, 10'h100, "sleep enables");
         wake_event = 4'h1 << i;
         step(1);
         wake_event = 4'h0;
         chk(power_state, lpss_pkg::LPSS_WAKEUP, "wake source");
         wait_state(lpss_pkg::LPSS_ON, 10);
      end
      $display("sleep wake done");
   endtask : t_sleep_wake

   task automatic t_deep;
      ret_addr = 2'h2;
      ret_wdata = 32'hc0de_0042;
      ret_wr_en = 1'b1;
      step(1);
      ret_wr_en = 1'b0;
      pad_hold_cfg = 1'b1;
      go_sleep(lpss_pkg::LPSS_MODE_DEEP);
      chk(power_state, lpss_pkg::LPSS_DEEP_SLEEP, "deep entry");
      chk({main_power_en, rtc_clk_en, rtc_domain_en}, 3, "deep power");
      chk(pad_oe_hold_low, 1, "pad hold");
      ret_wdata = 32'h0bad_0bad;
      ret_wr_en = 1'b1;
      cnt = rtc_count;
      step(5);
      ret_wr_en = 1'b0;
      chk(rtc_count - cnt, 5, "timer in deep");
      wake_event = 4'h2;
      step(1);
      wake_event = 4'h0;
      wait_state(lpss_pkg::LPSS_ON, 10);
      pad_hold_cfg = 1'b0;
      step(2);
      chk(ret_rdata, 32'hc0de_0042, "retention kept");
      chk(pad_oe_hold_low, 0, "pad hold off");
      $display("deep sleep done");
   endtask : t_deep

   task automatic t_timer_wake;
      rtc_alarm = rtc_count + 32'h20;
      go_sleep(lpss_pkg::LPSS_MODE_DEEP);
      chk(pad_oe_hold_low, 0, "no hold unless configured");
      for (int i = 0; i < 60 && wake_oe !== 1'b1; i++) step(1);
      chk({wake_oe, wake_o}, 2, "wake pin pulse");
      rtc_alarm = 32'hffff_ffff;
      wait_state(lpss_pkg::LPSS_OFF, 5);
      wait_state(lpss_pkg::LPSS_ON, 40);
      step(2);
      chk(ret_rdata, 0, "retention reset");
      $display("timer wake done");
   endtask : t_timer_wake

   task automatic t_chip_off;
      go_sleep(lpss_pkg::LPSS_MODE_SLEEP);
      chip_en = 1'b0;
      step(1);
      chk(power_state, lpss_pkg::LPSS_OFF, "forced off");
      chk(rtc_domain_en, 0, "always-on domain off");
      chk(block_clk_en, 0, "block clocks off");
      chk(rtc_count, 0, "timer cleared");
      chip_en = 1'b1;
      step(1);
      chk(power_state, lpss_pkg::LPSS_WAKEUP, "restart");
      $display("chip off done");
   endtask : t_chip_off

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         $display("BAD %0t run timed out", $time);
         finish_test();
      end
   end

   initial begin
      {rst, chip_en, board_reset_n, slow} = 4'hf;
      {sleep_req, clk_ctrl_wr, wfi, cpu_irq, pad_hold_cfg, ret_wr_en} = 6'h00;
      {sleep_mode_req, ret_addr, wake_event, clk_ctrl} = 16'h0000;
      rtc_alarm = 32'hffff_ffff;
      ret_wdata = 32'h0000_0000;
      step(6);
      t_power_up();
      t_gating();
      t_sleep_wake();
      t_deep();
      t_timer_wake();
      t_chip_off();
      finish_test();
   end
endmodule : lpss_seq_tb
